// file: smw_pkg.sv
// Operation
// - Address and data lead the strobe fall by the strobe setup count.
// - The write strobe stays low for exactly the strobe pulse count.
// - Address and data stay for the strobe hold count after the strobe rises.
// - Write select timing has its own settings, apart from read timing.
// - The address leads the chip-select fall by the chip-select setup count.
// - Chip select stays low for exactly the chip-select pulse count.
// - The address stays for the select hold count after chip select rises.
// - A write cycle runs from the address being driven until it may change.
// - Cycle length equals setup+pulse+hold for strobe and for chip select.
// - Each chip select has its own strobe and select timings in whole clocks.
// - One cycle length per chip select governs both strobe and chip select.
// - Strobe hold is cycle length minus strobe setup minus strobe pulse.
package smw_pkg;
    localparam int unsigned NUM_CS = 4;
    localparam int unsigned CS_W = 2;
    localparam int unsigned ADDR_W = 24;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    // One write request as carried through the buffer
    typedef struct packed {
        logic [CS_W-1:0] cs;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } smw_req_s;

    // Per chip-select write timing, all counts in clock cycles
    typedef struct packed {
        logic [CNT_W-1:0] we_setup_cycles;
        logic [CNT_W-1:0] we_pulse_cycles;
        logic [CNT_W-1:0] cs_wr_setup_cycles;
        logic [CNT_W-1:0] cs_wr_pulse_cycles;
        logic [CNT_W-1:0] write_cycle_length;
    } smw_timing_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_RUN = 2'b11
    } smw_state_e;
endpackage

// file: smw_write_engine.sv
// Write waveform generator with a two-entry request buffer in front.
module smw_write_engine (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Per chip-select timing settings
    input wire smw_pkg::smw_timing_s timing [smw_pkg::NUM_CS],
    // Request stream
    input wire logic req_valid,
    output logic req_ready,
    input wire smw_pkg::smw_req_s req,
    // Memory pins
    output logic [smw_pkg::ADDR_W-1:0] mem_addr,
    output logic [smw_pkg::DATA_W-1:0] mem_data_out,
    output logic mem_data_oe_n,
    output logic write_strobe_n,
    output logic [smw_pkg::NUM_CS-1:0] chip_select_n,
    // Status
    output logic busy,
    output logic timing_error
);
    import smw_pkg::*;

    // Two-entry buffer: fill side and drain side pointers
    smw_req_s buf_reg [2];
    smw_req_s buf_next [2];
    logic [1:0] count_reg, count_next;
    logic rd_ptr_reg, rd_ptr_next, wr_ptr_reg, wr_ptr_next;
    logic buf_push, buf_pop;
    smw_req_s head;

    // Engine state
    smw_state_e state_reg, state_next;
    smw_req_s cur_reg, cur_next;
    smw_timing_s tim_reg, tim_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] data_reg, data_next;
    logic oe_n_reg, oe_n_next;
    logic we_n_reg, we_n_next;
    logic [NUM_CS-1:0] cs_n_reg, cs_n_next;
    logic err_reg, err_next;
    logic ready_reg, ready_next;
    logic busy_reg, busy_next;
    smw_timing_s sel_t;
    logic [CNT_W:0] we_end, cs_end;

    // Sizes checked at elaboration; the select decode needs 2**CS_W selects
    if (NUM_CS != (1 << CS_W) || CNT_W < 2) begin : g_bad_sizes
        $error("smw_write_engine: unsupported sizes");
    end

    assign head = buf_reg[rd_ptr_reg];
    assign buf_push = req_valid && ready_reg;
    // Engine drains only when idle, so a busy bus back-pressures the source
    assign buf_pop = (state_reg == ST_IDLE) && (count_reg != 2'h0);
    assign sel_t = timing[head.cs];

    // Pulse ends one bit wider, so large settings cannot wrap the compare
    assign we_end = {1'b0, tim_reg.we_setup_cycles}
        + {1'b0, tim_reg.we_pulse_cycles};
    assign cs_end = {1'b0, tim_reg.cs_wr_setup_cycles}
        + {1'b0, tim_reg.cs_wr_pulse_cycles};

    // Buffer next state
    always_comb begin
        buf_next = buf_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        if (buf_push) begin
            buf_next[wr_ptr_reg] = req;
            wr_ptr_next = ~wr_ptr_reg;
        end
        if (buf_pop) begin
            rd_ptr_next = ~rd_ptr_reg;
        end
        case ({buf_push, buf_pop})
            2'b10: count_next = count_reg + 2'h1;
            2'b01: count_next = count_reg - 2'h1;
            default: count_next = count_reg;
        endcase
        ready_next = (count_next < 2'h2);
    end

    // Buffer registers; ready is registered so it drives straight out
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            buf_reg[0] <= '0;
            buf_reg[1] <= '0;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
            ready_reg <= 1'b0;
        end else begin
            buf_reg <= buf_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
            ready_reg <= ready_next;
        end
    end

    // Waveform next state; cnt counts cycles elapsed within the cycle.
    // Each pin is a pure function of cnt, so setup/pulse/hold are exact.
    always_comb begin
        state_next = state_reg;
        cur_next = cur_reg;
        tim_next = tim_reg;
        cnt_next = cnt_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        oe_n_next = oe_n_reg;
        we_n_next = 1'b1;
        cs_n_next = '1;
        err_next = err_reg;
        case (state_reg)
            ST_IDLE: begin
                oe_n_next = 1'b1;
                if (buf_pop) begin
                    cur_next = head;
                    tim_next = sel_t;
                    state_next = ST_LOAD;
                end
            end
            ST_LOAD: begin
                // Address and data go out; this is cycle 0 of the write
                addr_next = cur_reg.addr;
                data_next = cur_reg.data;
                oe_n_next = 1'b0;
                cnt_next = CNT_ZERO;
                // Flag settings whose strobe or select would overrun
                err_next = (we_end > {1'b0, tim_reg.write_cycle_length})
                    || (cs_end > {1'b0, tim_reg.write_cycle_length});
                if (tim_reg.we_setup_cycles == CNT_ZERO
                        && tim_reg.we_pulse_cycles != CNT_ZERO) begin
                    we_n_next = 1'b0;
                end
                if (tim_reg.cs_wr_setup_cycles == CNT_ZERO
                        && tim_reg.cs_wr_pulse_cycles != CNT_ZERO) begin
                    cs_n_next[cur_reg.cs] = 1'b0;
                end
                if (tim_reg.write_cycle_length <= CNT_ONE) begin
                    state_next = ST_IDLE;
                end else begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                cnt_next = cnt_reg + CNT_ONE;
                // Strobe low from setup to setup+pulse; hold is the rest
                if (cnt_next >= tim_reg.we_setup_cycles
                        && {1'b0, cnt_next} < we_end) begin
                    we_n_next = 1'b0;
                end
                if (cnt_next >= tim_reg.cs_wr_setup_cycles
                        && {1'b0, cnt_next} < cs_end) begin
                    cs_n_next[cur_reg.cs] = 1'b0;
                end
                // Address only released after the whole cycle count
                if (cnt_next + CNT_ONE >= tim_reg.write_cycle_length) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // Busy from the pop until the last pin cycle has gone out
        busy_next = (state_next != ST_IDLE) || (state_reg != ST_IDLE);
    end

    // Waveform registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            cur_reg <= '0;
            tim_reg <= '0;
            cnt_reg <= CNT_ZERO;
            addr_reg <= '0;
            data_reg <= '0;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            cs_n_reg <= '1;
            err_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cur_reg <= cur_next;
            tim_reg <= tim_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            oe_n_reg <= oe_n_next;
            we_n_reg <= we_n_next;
            cs_n_reg <= cs_n_next;
            err_reg <= err_next;
            busy_reg <= busy_next;
        end
    end

    // Low-time counters of the pins; they let the pulse checks cover any
    // programmed length rather than one fixed value
    logic [CNT_W-1:0] we_low_reg, we_low_next;
    logic [CNT_W-1:0] cs_low_reg, cs_low_next;

    always_comb begin
        we_low_next = CNT_ZERO;
        cs_low_next = CNT_ZERO;
        if (!we_n_reg) begin
            we_low_next = we_low_reg + CNT_ONE;
        end
        if (!(&cs_n_reg)) begin
            cs_low_next = cs_low_reg + CNT_ONE;
        end
    end

    // Counter registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            we_low_reg <= CNT_ZERO;
            cs_low_reg <= CNT_ZERO;
        end else begin
            we_low_reg <= we_low_next;
            cs_low_reg <= cs_low_next;
        end
    end

    assign req_ready = ready_reg;
    assign mem_addr = addr_reg;
    assign mem_data_out = data_reg;
    assign mem_data_oe_n = oe_n_reg;
    assign write_strobe_n = we_n_reg;
    assign chip_select_n = cs_n_reg;
    assign busy = busy_reg;
    assign timing_error = err_reg;

    // Strobe low only inside the drive window, over a steady address; a
    // zero setup lowers it in the very cycle the address first appears
    property p_addr_stable_strobe;
        @(posedge clk_sys) disable iff (sys_rst)
        !write_strobe_n |-> !mem_data_oe_n
            && (($stable(mem_addr) && $stable(mem_data_out))
            || $fell(mem_data_oe_n));
    endproperty
    a_addr_stable_strobe: assert property (p_addr_stable_strobe)
        else $error("address moved while write strobe low");

    property p_strobe_pulse_len;
        @(posedge clk_sys) disable iff (sys_rst)
        $fell(write_strobe_n) && !timing_error
            && tim_reg.we_pulse_cycles == 8'h02 |->
            !write_strobe_n ##1 !write_strobe_n ##1 write_strobe_n;
    endproperty
    a_strobe_pulse_len: assert property (p_strobe_pulse_len)
        else $error("write strobe pulse length wrong");

    property p_hold_after_strobe;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(write_strobe_n) && state_reg == ST_RUN |-> $stable(mem_addr);
    endproperty
    a_hold_after_strobe: assert property (p_hold_after_strobe)
        else $error("address changed at strobe rise");

    property p_cs_addr_stable;
        @(posedge clk_sys) disable iff (sys_rst)
        !(&chip_select_n) |-> !mem_data_oe_n
            && ($stable(mem_addr) || $fell(mem_data_oe_n));
    endproperty
    a_cs_addr_stable: assert property (p_cs_addr_stable)
        else $error("address moved while chip select low");

    property p_one_cs;
        @(posedge clk_sys) disable iff (sys_rst)
        $onehot0(~chip_select_n);
    endproperty
    a_one_cs: assert property (p_one_cs)
        else $error("more than one chip select low");

    // Any programmed strobe pulse, unless the settings were flagged
    property p_strobe_low_count;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(write_strobe_n) && !timing_error |->
            we_low_reg == tim_reg.we_pulse_cycles;
    endproperty
    a_strobe_low_count: assert property (p_strobe_low_count)
        else $error("write strobe low for the wrong number of clocks");

    property p_select_low_count;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(&chip_select_n) && !timing_error |->
            cs_low_reg == tim_reg.cs_wr_pulse_cycles;
    endproperty
    a_select_low_count: assert property (p_select_low_count)
        else $error("chip select low for the wrong number of clocks");

    property p_idle_high;
        @(posedge clk_sys) disable iff (sys_rst)
        state_reg == ST_IDLE && $past(state_reg) == ST_IDLE |->
            write_strobe_n && (&chip_select_n);
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("strobe or select low while idle");

    property p_no_overrun;
        @(posedge clk_sys) disable iff (sys_rst)
        state_reg == ST_RUN |-> cnt_reg < tim_reg.write_cycle_length;
    endproperty
    a_no_overrun: assert property (p_no_overrun)
        else $error("write cycle ran past its length");

    property p_buf_honest;
        @(posedge clk_sys) disable iff (sys_rst)
        count_reg == 2'h2 |-> !req_ready;
    endproperty
    a_buf_honest: assert property (p_buf_honest)
        else $error("ready high while buffer full");
endmodule // smw_write_engine

// file: smw_mem_model.sv
// Far-side static memory: logs each word when its strobe and select overlap ends.
module smw_mem_model (
    // Clock
    input wire logic clk_sys,
    // Memory pins
    input wire logic [smw_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [smw_pkg::DATA_W-1:0] mem_data_out,
    input wire logic write_strobe_n,
    input wire logic [smw_pkg::NUM_CS-1:0] chip_select_n
);
    import smw_pkg::*;
    smw_req_s log_q[$];
    smw_req_s pend;
    logic armed = 1'b0;

    // A word is written while strobe and a select are both low; it is
    // logged when that overlap ends, so a zero hold still stores it
    always @(negedge clk_sys) begin
        if (write_strobe_n === 1'b0 && chip_select_n !== '1) begin
            pend.addr = mem_addr;
            pend.data = mem_data_out;
            for (int i = 0; i < NUM_CS; i++)
                if (chip_select_n[i] === 1'b0) pend.cs = CS_W'(i);
            armed = 1'b1;
        end else if (armed) begin
            log_q.push_back(pend);
            armed = 1'b0;
        end
    end
endmodule // smw_mem_model

// file: static_memory_write_timing_tb.sv
module static_memory_write_timing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import smw_pkg::*;
    typedef struct packed {
        logic [7:0] ws, wp, cs_st, cp, len;
        logic [3:0] sel;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } smw_wave_s;
    logic clk_sys, sys_rst, req_valid, req_ready, mem_data_oe_n;
    logic write_strobe_n, busy, timing_error, saw_full;
    smw_timing_s timing [NUM_CS];
    smw_req_s req, m;
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] mem_data_out;
    logic [NUM_CS-1:0] chip_select_n;
    int n_errors, checks_done, idx, bad_hold, bad_idle, bad_busy;
    smw_wave_s cur;
    smw_wave_s wave_q[$];

    smw_write_engine u_smw_write_engine (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .timing(timing), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .mem_addr(mem_addr),
        .mem_data_out(mem_data_out), .mem_data_oe_n(mem_data_oe_n),
        .write_strobe_n(write_strobe_n), .chip_select_n(chip_select_n),
        .busy(busy), .timing_error(timing_error));
    smw_mem_model u_smw_mem_model (.clk_sys(clk_sys), .mem_addr(mem_addr),
        .mem_data_out(mem_data_out), .write_strobe_n(write_strobe_n),
        .chip_select_n(chip_select_n));

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Measures each write cycle in clocks from the first cycle of oe_n low
    always @(negedge clk_sys) begin
        if (sys_rst === 1'b1) begin
            idx = 0;
        end else if (mem_data_oe_n === 1'b0) begin
            if (idx == 0) begin
                cur = '{ws: 8'hff, cs_st: 8'hff, addr: mem_addr,
                    data: mem_data_out, default: '0};
            end else if (mem_addr !== cur.addr || mem_data_out !== cur.data)
                bad_hold++;
            if (write_strobe_n === 1'b0) begin
                if (cur.ws == 8'hff) cur.ws = 8'(idx);
                cur.wp++;
            end
            if (chip_select_n !== 4'hf) begin
                if (cur.cs_st == 8'hff) cur.cs_st = 8'(idx);
                cur.cp++;
                cur.sel = ~chip_select_n;
            end
            if (busy !== 1'b1) bad_busy++;
            idx++;
        end else begin
            if (write_strobe_n !== 1'b1 || chip_select_n !== 4'hf) bad_idle++;
            if (idx != 0) begin
                cur.len = 8'(idx);
                wave_q.push_back(cur);
                idx = 0;
            end
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic send(input int cs, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(negedge clk_sys);
        if (req_ready !== 1'b1) saw_full = 1'b1;
        while (req_ready !== 1'b1 && n < 500) begin
            @(negedge clk_sys);
            n++;
        end
        req_valid = 1'b1;
        req = '{cs: CS_W'(cs), addr: a, data: d};
        @(negedge clk_sys);
        req_valid = 1'b0;
    endtask

    task automatic take(output smw_wave_s w);
        int n;
        n = 0;
        w = '0;
        while (wave_q.size() == 0 && n < 1000) begin
            @(negedge clk_sys);
            n++;
        end
        #1;
        chk("wave count", 32'(wave_q.size() > 0), 1);
        if (wave_q.size() > 0) w = wave_q.pop_front();
    endtask

    task automatic expect_wave(input int cs, input logic [ADDR_W-1:0] a,
                               input logic [DATA_W-1:0] d);
        smw_wave_s w;
        take(w);
        chk("we setup", w.ws, timing[cs].we_setup_cycles);
        chk("we pulse", w.wp, timing[cs].we_pulse_cycles);
        chk("cs setup", w.cs_st, timing[cs].cs_wr_setup_cycles);
        chk("cs pulse", w.cp, timing[cs].cs_wr_pulse_cycles);
        chk("length", w.len, timing[cs].write_cycle_length);
        chk("select", w.sel, 32'h1 << cs);
        chk("addr", w.addr, a);
        chk("data", w.data, d);
        chk("no error", timing_error, 0);
        chk("mem log", u_smw_mem_model.log_q.size(), 1);
        if (u_smw_mem_model.log_q.size() > 0) begin
            m = u_smw_mem_model.log_q.pop_front();
            chk("mem select", m.cs, cs);
            chk("mem addr", m.addr, a);
            chk("mem data", m.data, d);
        end
    endtask

    // Distinct timings per select, setup of zero at both ends; strobe and
    // select overlap in every cycle so the memory stores each word
    task automatic s_per_cs();
        logic [ADDR_W-1:0] a;
        for (int i = 0; i < NUM_CS; i++)
            timing[i] = '{8'(i), 8'(4 + i), 8'(3 - i), 8'(1 + i), 8'(8 + i)};
        for (int i = 0; i < NUM_CS; i++) begin
            a = 24'(24'h100 * i + 5);
            send(i, a, 16'ha50 + 16'(i));
            expect_wave(i, a, 16'ha50 + 16'(i));
        end
        $display("test per_cs done");
    endtask

    // Pulses that end on the last clock leave a zero hold
    task automatic s_zero_hold();
        @(negedge clk_sys);
        timing[1] = '{8'h2, 8'h3, 8'h0, 8'h5, 8'h5};
        send(1, 24'habcdef, 16'h1234);
        expect_wave(1, 24'habcdef, 16'h1234);
        $display("test zero_hold done");
    endtask

    // Four requests overrun the buffer; none may be lost or merged
    task automatic s_burst();
        @(negedge clk_sys);
        timing[2] = '{8'h1, 8'h2, 8'h1, 8'h2, 8'h8};
        saw_full = 1'b0;
        for (int i = 0; i < 4; i++) begin
            send(2, 24'h20000 + 24'(i), 16'hc0 + 16'(i));
        end
        chk("buffer full", saw_full, 1);
        for (int i = 0; i < 4; i++)
            expect_wave(2, 24'h20000 + 24'(i), 16'hc0 + 16'(i));
        $display("test burst done");
    endtask

    // Setup plus pulse past the length is flagged and the length kept
    task automatic s_error();
        smw_wave_s w;
        @(negedge clk_sys);
        timing[3] = '{8'h3, 8'h4, 8'h1, 8'h1, 8'h5};
        send(3, 24'h3, 16'h3);
        take(w);
        chk("length kept", w.len, 5);
        chk("we setup kept", w.ws, 3);
        chk("we clipped", w.wp, 2);
        chk("error flag", timing_error, 1);
        u_smw_mem_model.log_q.delete();
        $display("test error done");
    endtask

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        timing = '{default: '0};
        repeat (8) @(negedge clk_sys);
        chk("ready in reset", req_ready, 0);
        chk("busy in reset", busy, 0);
        sys_rst = 1'b0;
        @(negedge clk_sys);
        chk("ready", req_ready, 1);
        s_per_cs();
        s_zero_hold();
        s_burst();
        s_error();
        chk("addr stable", bad_hold, 0);
        chk("idle high", bad_idle, 0);
        chk("busy in cycle", bad_busy, 0);
        chk("idle busy", busy, 0);
        summarize();
    end

    // Watchdog, far beyond the hundred-odd clocks the tests need
    initial begin
        #200us;
        n_errors++;
        summarize();
    end
endmodule // static_memory_write_timing_tb
